/* File: inc/pps_defs.vh */
// constants for the port sequencer and legacy capacitance result block
// assumes inclusion by bare name from the logic files
`ifndef PPS_DEFS_VH
`define PPS_DEFS_VH
// ----------------------------------------
// register command codes
// ----------------------------------------
`define PPS_PORT3_CAP_LOW 8'h6c
`define PPS_PORT3_CAP_HIGH 8'h6d
`define PPS_PORT4_CAP_LOW 8'h6e
`define PPS_PORT4_CAP_HIGH 8'h6f
`define PPS_RSVD_A 8'h1b
`define PPS_RSVD_B 8'h1d
`define PPS_RSVD_C 8'h1e
`define PPS_RSVD_D 8'h1f
`define PPS_RSVD_E 8'h22
`define PPS_RSVD_F 8'h23
`define PPS_RSVD_G 8'h24
`define PPS_RSVD_H 8'h25
`define PPS_RSVD_I 8'h59
// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define PPS_CNT_W 12
`define PPS_STAT_LSB 4
`define PPS_CNT_HI_MSB 11
`define PPS_CNT_HI_LSB 8
`define PPS_CAP_RESET 8'h00
// step of one count, microvolts
`define PPS_STEP_UV 4884
// ----------------------------------------
// measurement status codes
// ----------------------------------------
`define PPS_VS_POR 4'h0
`define PPS_VS_VALID 4'h1
`define PPS_VS_DISCH_TMO 4'h2
`define PPS_VS_FIRST_TMO 4'h3
`define PPS_VS_FIRST_CLAMP 4'h4
`define PPS_VS_SECOND_CLAMP 4'h5
`define PPS_VS_LOW_SIGNAL 4'h6
// ----------------------------------------
// timing
// ----------------------------------------
`define PPS_CLK_HZ 125000000
`define PPS_COOL_1S_MS 1000
`define PPS_COOL_2S_MS 2000
`define PPS_COOL_4S_MS 4000
`define PPS_CYC_PER_MS (`PPS_CLK_HZ / 1000)
`endif

/* File: logic/pps_cap_result.v */
// one port's capacitance result register pair
// assumes meas inputs are synchronous single-cycle strobes from the front end
`include "pps_defs.vh"
module pps_cap_result (
  input wire clk,
  input wire rst_n,
  input wire legacyEn,
  input wire measDone,
  input wire [3:0] measStatus,
  input wire [11:0] measCount,
  output wire [7:0] lowByte,
  output wire [7:0] highByte
);
  reg [3:0] status_q;
  reg [11:0] count_q;
  reg legacyEn_q;
  // ----------------------------------------
  // capture
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= `PPS_VS_POR;
      count_q <= 12'h000;
      legacyEn_q <= 1'b0;
    end else begin
      legacyEn_q <= legacyEn;
      // status and count are loaded in one edge so a pair never mixes
      if (legacyEn && measDone) begin
        status_q <= measStatus;
        count_q <= measCount;
      end else if (legacyEn && !legacyEn_q) begin
        status_q <= `PPS_VS_POR;
      end
      // otherwise held in every mode
    end
  end
  assign lowByte = count_q[7:0];
  assign highByte = {status_q, count_q[11:8]};
endmodule // pps_cap_result

/* File: logic/pps_cool_timer.v */
// cool-down timer for one port
// assumes start is a one-cycle strobe; sel is stable while counting
`include "pps_defs.vh"
module pps_cool_timer #(
  parameter CYC_PER_MS = `PPS_CYC_PER_MS
) (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire [1:0] sel,
  output reg done
);
  reg [31:0] cnt_q;
  reg run_q;
  reg [31:0] limit;
  always @* begin
    case (sel)
      2'h2: limit = `PPS_COOL_2S_MS * CYC_PER_MS;
      2'h3: limit = `PPS_COOL_4S_MS * CYC_PER_MS;
      default: limit = `PPS_COOL_1S_MS * CYC_PER_MS;
    endcase
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0;
      run_q <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_q <= 32'h1;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q >= limit) begin
          run_q <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 32'h1;
        end
      end
    end
  end
endmodule // pps_cool_timer

/* File: logic/pps_port_seq.v */
// Function
// - host reads the port 3 and port 4 results as two read-only bytes, low first
// - low byte count[7:0]; high byte status[7:4], count[11:8]; reset zero
// - inject fixed charge and report voltage change as 12-bit count
// - one count equals a fixed 4.884 mV step
// - measure only when legacy detection is enabled for that port
// - status holds power-on code after enable until a measurement completes
// - count stays in every mode until a later measurement replaces it; status also returns to power-on code when enable rises
// - status codes 2..6 name discharge, first level, clamp, signal failures
// - auto mode detects, classifies up to class 4, then powers
// - powered port shuts on faults and removes power on disconnect
// - after power-off command or disconnect, detect again at once
// - after start, cut or hard-limit fault, cool down then detect
// - no power without valid detect or with bad classification
// - lock out when main supply falls below its falling threshold
// - cool-down select 0x gives 1 s, 10 gives 2 s, 11 gives 4 s
//
// top of the port sequencer: result registers of ports 3 and 4 and the
// automatic sequencing of all four ports
// assumes analog front end strobes arrive on clk; the uvlo comparator is an
// asynchronous pin and is synchronised here
`include "pps_defs.vh"
module pps_port_seq #(
  parameter NPORT = 4,
  parameter CYC_PER_MS = `PPS_CYC_PER_MS
) (
  input wire clk,
  input wire rst_n,
  // register read and write port
  input wire regRd,
  input wire regWr,
  input wire [7:0] regAddr,
  output reg [7:0] regRdData,
  output reg rsvdWriteSeen,
  // mode and configuration
  input wire autoMode,
  input wire [NPORT-1:0] legacyEn,
  input wire [1:0] cooldown_period_sel,
  input wire [NPORT-1:0] powerOffCmd,
  input wire supplyBelowUv,
  // front end strobes per port
  input wire [NPORT-1:0] detDone,
  input wire [NPORT-1:0] detValid,
  input wire [NPORT-1:0] clsDone,
  input wire [NPORT*3-1:0] clsResult,
  input wire [NPORT-1:0] startFault,
  input wire [NPORT-1:0] overload_cut_limit,
  input wire [NPORT-1:0] hard_current_limit,
  input wire [NPORT-1:0] mpsLost,
  input wire [NPORT-1:0] capDone,
  input wire [NPORT*4-1:0] capStatus,
  input wire [NPORT*12-1:0] capCount,
  // per-port outputs and supply lockout
  output wire [NPORT-1:0] detectReq,
  output wire [NPORT-1:0] classReq,
  output wire [NPORT-1:0] capMeasReq,
  output wire [NPORT-1:0] portPowerEn,
  output wire [NPORT*3-1:0] portClass,
  output reg uvLockout
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_DETECT = 3'h1;
  localparam ST_CAPMEAS = 3'h2;
  localparam ST_CLASS = 3'h3;
  localparam ST_POWER = 3'h4;
  localparam ST_COOL = 3'h5;
  // class result codes from the front end
  localparam CLS_MAX = 3'h4;
  localparam CLS_OVERCUR = 3'h5;
  localparam CLS_MISMATCH = 3'h6;
  localparam CLS_UNKNOWN = 3'h7;

  // ----------------------------------------
  // supply comparator synchroniser
  // ----------------------------------------
  // resets to locked so no port acts before the supply is known good
  reg uvMeta_q;
  reg uvSync_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uvMeta_q <= 1'b1;
      uvSync_q <= 1'b1;
      uvLockout <= 1'b1;
    end else begin
      uvMeta_q <= supplyBelowUv;
      uvSync_q <= uvMeta_q;
      uvLockout <= uvSync_q;
    end
  end

  // ----------------------------------------
  // per-port sequencer
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : gPort
      reg [2:0] state_q;
      reg [2:0] state_d;
      reg detReq_q;
      reg detReq_d;
      reg clsReq_q;
      reg clsReq_d;
      reg capReq_q;
      reg capReq_d;
      reg power_q;
      reg power_d;
      reg [2:0] class_q;
      reg [2:0] class_d;
      reg coolStart_q;
      reg coolStart_d;
      wire coolDone;
      wire [2:0] cls = clsResult[g*3 +: 3];
      wire fault = startFault[g] | overload_cut_limit[g] |
                   hard_current_limit[g];
      // classes the front end cannot serve are refused outright
      wire clsBad = (cls == CLS_OVERCUR) || (cls == CLS_MISMATCH) ||
                    (cls == CLS_UNKNOWN) || (cls > CLS_MAX);

      // one timer per port so a fault on one never delays another
      pps_cool_timer #(
        .CYC_PER_MS(CYC_PER_MS)
      ) uCool (
        .clk(clk),
        .rst_n(rst_n),
        .start(coolStart_q),
        .sel(cooldown_period_sel),
        .done(coolDone)
      );

      // ----------------------------------------
      // next state
      // ----------------------------------------
      always @* begin
        state_d = state_q;
        detReq_d = detReq_q;
        clsReq_d = clsReq_q;
        capReq_d = capReq_q;
        power_d = power_q;
        class_d = class_q;
        coolStart_d = 1'b0;
        // lockout or leaving auto drops the port; host owns it then
        if (uvLockout || !autoMode) begin
          state_d = ST_IDLE;
          detReq_d = 1'b0;
          clsReq_d = 1'b0;
          capReq_d = 1'b0;
          power_d = 1'b0;
        end else begin
          case (state_q)
            ST_IDLE: begin
              state_d = ST_DETECT;
              detReq_d = 1'b1;
            end
            ST_DETECT: begin
              // a failed signature falls back to the capacitance check when legacy is enabled, else to idle
              if (detDone[g]) begin
                detReq_d = 1'b0;
                if (detValid[g]) begin
                  state_d = ST_CLASS;
                  clsReq_d = 1'b1;
                end else if (legacyEn[g]) begin
                  state_d = ST_CAPMEAS;
                  capReq_d = 1'b1;
                end else begin
                  state_d = ST_IDLE;
                end
              end
            end
            ST_CAPMEAS: begin
              // legacy result is reported only; never powers the port
              if (capDone[g]) begin
                capReq_d = 1'b0;
                state_d = ST_IDLE;
              end
            end
            ST_CLASS: begin
              if (clsDone[g]) begin
                clsReq_d = 1'b0;
                if (clsBad) begin
                  state_d = ST_IDLE;
                end else begin
                  // class steers the front end's cut threshold
                  class_d = cls;
                  power_d = 1'b1;
                  state_d = ST_POWER;
                end
              end
            end
            ST_POWER: begin
              // a fault outranks a disconnect: a tripped port must cool
              if (fault) begin
                power_d = 1'b0;
                coolStart_d = 1'b1;
                state_d = ST_COOL;
              end else if (powerOffCmd[g] || mpsLost[g]) begin
                power_d = 1'b0;
                state_d = ST_DETECT;
                detReq_d = 1'b1;
              end
            end
            ST_COOL: begin
              // no detection until the whole period has run out
              if (coolDone) begin
                state_d = ST_DETECT;
                detReq_d = 1'b1;
              end
            end
            default: begin
              state_d = ST_IDLE;
            end
          endcase
        end
      end

      // ----------------------------------------
      // port flops
      // ----------------------------------------
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          state_q <= ST_IDLE;
          detReq_q <= 1'b0;
          clsReq_q <= 1'b0;
          capReq_q <= 1'b0;
          power_q <= 1'b0;
          class_q <= 3'h0;
          coolStart_q <= 1'b0;
        end else begin
          state_q <= state_d;
          detReq_q <= detReq_d;
          clsReq_q <= clsReq_d;
          capReq_q <= capReq_d;
          power_q <= power_d;
          class_q <= class_d;
          coolStart_q <= coolStart_d;
        end
      end

      // each port bit comes straight from its own flop
      assign detectReq[g] = detReq_q;
      assign classReq[g] = clsReq_q;
      assign capMeasReq[g] = capReq_q;
      assign portPowerEn[g] = power_q;
      assign portClass[g*3 +: 3] = class_q;
    end
  endgenerate

  // ----------------------------------------
  // legacy result registers, ports 3 and 4
  // ----------------------------------------
  wire [7:0] p3Low;
  wire [7:0] p3High;
  wire [7:0] p4Low;
  wire [7:0] p4High;
  // ports 1 and 2 keep no result registers in this block
  // count passes unscaled; one count is one fixed step
  pps_cap_result uRes3 (
    .clk(clk),
    .rst_n(rst_n),
    .legacyEn(legacyEn[2]),
    .measDone(capDone[2]),
    .measStatus(capStatus[11:8]),
    .measCount(capCount[35:24]),
    .lowByte(p3Low),
    .highByte(p3High)
  );
  pps_cap_result uRes4 (
    .clk(clk),
    .rst_n(rst_n),
    .legacyEn(legacyEn[3]),
    .measDone(capDone[3]),
    .measStatus(capStatus[15:12]),
    .measCount(capCount[47:36]),
    .lowByte(p4Low),
    .highByte(p4High)
  );

  // ----------------------------------------
  // register read
  // ----------------------------------------
  // high byte is snapshotted when the low byte is read, so a two-byte
  // transfer returns one measurement even if a new one lands between
  reg [7:0] p3HighSnap_q;
  reg [7:0] p4HighSnap_q;
  reg [7:0] rdNext;
  // a host write to these codes is refused and only flagged
  wire isRsvd = (regAddr == `PPS_RSVD_A) || (regAddr == `PPS_RSVD_B) ||
                (regAddr == `PPS_RSVD_C) || (regAddr == `PPS_RSVD_D) ||
                (regAddr == `PPS_RSVD_E) || (regAddr == `PPS_RSVD_F) ||
                (regAddr == `PPS_RSVD_G) || (regAddr == `PPS_RSVD_H) ||
                (regAddr == `PPS_RSVD_I);
  // unmapped codes read as zero
  always @* begin
    case (regAddr)
      `PPS_PORT3_CAP_LOW: rdNext = p3Low;
      `PPS_PORT3_CAP_HIGH: rdNext = p3HighSnap_q;
      `PPS_PORT4_CAP_LOW: rdNext = p4Low;
      `PPS_PORT4_CAP_HIGH: rdNext = p4HighSnap_q;
      default: rdNext = 8'h00;
    endcase
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= `PPS_CAP_RESET;
    end else if (regRd) begin
      regRdData <= rdNext;
    end
  end

  // ----------------------------------------
  // high byte snapshots
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p3HighSnap_q <= `PPS_CAP_RESET;
      p4HighSnap_q <= `PPS_CAP_RESET;
    end else begin
      if (regRd && regAddr == `PPS_PORT3_CAP_LOW) begin
        p3HighSnap_q <= p3High;
      end
      if (regRd && regAddr == `PPS_PORT4_CAP_LOW) begin
        p4HighSnap_q <= p4High;
      end
    end
  end

  // ----------------------------------------
  // reserved write flag
  // ----------------------------------------
  // reserved writes are dropped; flag only, sticky until reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsvdWriteSeen <= 1'b0;
    end else if (regWr && isRsvd) begin
      rsvdWriteSeen <= 1'b1;
    end
  end
endmodule // pps_port_seq

/* File: verification/pps_port_seq_chk.sv */
// checker for the port sequencer top
// assumes it is bound onto pps_port_seq and sees only its ports
module pps_port_seq_chk #(
  parameter NPORT = 4
) (
  input logic clk,
  input logic rst_n,
  input logic regRd,
  input logic [7:0] regAddr,
  input logic [7:0] regRdData,
  input logic autoMode,
  input logic [NPORT-1:0] legacyEn,
  input logic [NPORT-1:0] powerOffCmd,
  input logic supplyBelowUv,
  input logic [NPORT-1:0] clsDone,
  input logic [NPORT-1:0] startFault,
  input logic [NPORT-1:0] mpsLost,
  input logic [NPORT-1:0] detectReq,
  input logic [NPORT-1:0] capMeasReq,
  input logic [NPORT-1:0] portPowerEn,
  input logic uvLockout
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // --------------
  // assertions
  // --------------
  chk_unmapped_zero: assert property (
    regRd && regAddr[7:2] != 6'h1b |=> regRdData == 8'h00)
    else $error("unmapped read gave data");
  chk_uv_follow: assert property (
    $rose(supplyBelowUv) |-> ##[1:4] uvLockout)
    else $error("lockout missed");
  // two cycles of lockout so the drop edge itself is not judged
  chk_uv_idle: assert property (
    uvLockout [*2] |-> portPowerEn == '0 && detectReq == '0)
    else $error("port active in lockout");
  chk_manual_idle: assert property (
    !autoMode ##1 !autoMode |-> portPowerEn == '0 && capMeasReq == '0)
    else $error("port active outside auto");
  chk_legacy_gate: assert property (
    (capMeasReq & ~$past(capMeasReq) & ~$past(legacyEn)) == '0)
    else $error("measure without enable");
  chk_class_power: assert property (
    $rose(portPowerEn[0]) |-> $past(clsDone[0]) || $past(clsDone[0], 2))
    else $error("power without class");
  chk_off_redetect: assert property (
    portPowerEn[0] && (powerOffCmd[0] || mpsLost[0])
    |-> ##[1:2] (detectReq[0] && !portPowerEn[0]))
    else $error("no redetect after off");
  chk_fault_cool: assert property (
    portPowerEn[0] && startFault[0]
    |=> (!detectReq[0] && !portPowerEn[0]) [*8])
    else $error("no cool-down after fault");
  cover property ($rose(portPowerEn[0]));
  cover property ($rose(capMeasReq[2]));
  cover property (portPowerEn[0] && startFault[0]);
endmodule // pps_port_seq_chk

bind pps_port_seq pps_port_seq_chk #(.NPORT(NPORT)) pps_port_seq_chk_inst (
  .clk(clk), .rst_n(rst_n), .regRd(regRd), .regAddr(regAddr),
  .regRdData(regRdData), .autoMode(autoMode), .legacyEn(legacyEn),
  .powerOffCmd(powerOffCmd), .supplyBelowUv(supplyBelowUv),
  .clsDone(clsDone), .startFault(startFault), .mpsLost(mpsLost),
  .detectReq(detectReq), .capMeasReq(capMeasReq),
  .portPowerEn(portPowerEn), .uvLockout(uvLockout));

/* File: verification/pps_pd_model.sv */
// far side of the four ports: front end and loads
// assumes requests are held until the matching done
module pps_pd_model (
  input logic clk,
  input logic [3:0] detectReq,
  input logic [3:0] classReq,
  input logic [3:0] capMeasReq,
  input logic [3:0] vld,
  input logic [2:0] cls,
  input logic [3:0] stat,
  input logic [11:0] cnt,
  input logic [3:0] lat,
  output logic [3:0] detDone = 4'h0,
  output logic [3:0] detValid,
  output logic [3:0] clsDone = 4'h0,
  output logic [11:0] clsResult,
  output logic [3:0] capDone = 4'h0,
  output logic [15:0] capStatus,
  output logic [47:0] capCount
);
  logic [3:0] age [4] = '{4{4'h0}};
  logic hit;
  // results toggle outside done so a stale value is never trusted
  always @(posedge clk) begin
    for (int p = 0; p < 4; p++) begin
      hit = age[p] == lat;
      detDone[p] <= hit && detectReq[p];
      clsDone[p] <= hit && classReq[p];
      capDone[p] <= hit && capMeasReq[p];
      age[p] <= (hit || !(detectReq[p] | classReq[p] | capMeasReq[p]))
        ? 4'h0 : age[p] + 4'h1;
      detValid[p] <= hit ? vld[p] : ~detValid[p];
      clsResult[p*3+:3] <= hit ? cls : ~clsResult[p*3+:3];
      capStatus[p*4+:4] <= hit ? stat : ~capStatus[p*4+:4];
      capCount[p*12+:12] <= hit ? cnt : ~capCount[p*12+:12];
    end
  end
endmodule // pps_pd_model

/* File: verification/pps_port_seq_tb.sv */
// self-checking bench for the port sequencer top
// assumes the design, its checker and pps_pd_model are compiled first
module pps_port_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPM = 2;
  logic clk = 1'b0, rst_n = 1'b0, regRd = 1'b0, regWr = 1'b0;
  logic autoMode = 1'b0, supplyBelowUv = 1'b0, rdSeen = 1'b0;
  logic rsvdWriteSeen, uvLockout;
  logic [7:0] regAddr = 8'h00, regRdData;
  logic [1:0] cooldown_period_sel = 2'h0;
  logic [3:0] legacyEn = 4'h0, powerOffCmd = 4'h0, startFault = 4'h0;
  logic [3:0] overload_cut_limit = 4'h0, hard_current_limit = 4'h0;
  logic [3:0] mpsLost = 4'h0, vld = 4'h1, lat = 4'h1, stat = 4'h1;
  logic [3:0] detDone, detValid, clsDone, capDone, detectReq, classReq;
  logic [3:0] capMeasReq, portPowerEn;
  logic [2:0] cls = 3'h0;
  logic [11:0] cnt = 12'h000, oc, clsResult, portClass;
  logic [15:0] capStatus;
  logic [47:0] capCount;
  logic [7:0] expQ [$];
  int errors = 0, tests_run = 0, cyc = 0, n, ex;
  always #4 clk = ~clk;
  pps_port_seq #(.CYC_PER_MS(CPM)) pps_port_seq_inst (
    .clk(clk), .rst_n(rst_n), .regRd(regRd), .regWr(regWr),
    .regAddr(regAddr), .regRdData(regRdData), .rsvdWriteSeen(rsvdWriteSeen),
    .autoMode(autoMode), .legacyEn(legacyEn), .powerOffCmd(powerOffCmd),
    .cooldown_period_sel(cooldown_period_sel), .mpsLost(mpsLost),
    .supplyBelowUv(supplyBelowUv), .detDone(detDone), .detValid(detValid),
    .clsDone(clsDone), .clsResult(clsResult), .startFault(startFault),
    .overload_cut_limit(overload_cut_limit), .capDone(capDone),
    .hard_current_limit(hard_current_limit), .capCount(capCount),
    .capStatus(capStatus), .detectReq(detectReq), .classReq(classReq),
    .capMeasReq(capMeasReq), .portPowerEn(portPowerEn),
    .portClass(portClass), .uvLockout(uvLockout));
  pps_pd_model pps_pd_model_inst (
    .clk(clk), .detectReq(detectReq), .classReq(classReq),
    .capMeasReq(capMeasReq), .vld(vld), .cls(cls), .stat(stat), .cnt(cnt),
    .lat(lat), .detDone(detDone), .detValid(detValid), .clsDone(clsDone),
    .clsResult(clsResult), .capDone(capDone), .capStatus(capStatus),
    .capCount(capCount));
  // --------------
  // tasks
  // --------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    expQ.push_back(e);
  endtask
  // low byte first: it snapshots the high byte
  task automatic rdp(input logic [7:0] a, input logic [3:0] s,
                     input logic [11:0] c);
    rd(a, c[7:0]);
    rd(a + 8'h01, {s, c[11:8]});
    tick(1);
    regRd <= 1'b0;
  endtask
  task automatic give_verdict;
    if (errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // --------------
  // monitor and timeout
  // --------------
  always @(posedge clk) rdSeen <= regRd;
  always @(negedge clk) begin
    if (rdSeen) cmp(regRdData, expQ.pop_front());
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      give_verdict();
    end
  end
  // --------------
  // scenarios
  // --------------
  initial begin
    n = $urandom(32'ha9e1);
    tick(12);
    rst_n <= 1'b1;
    tick(6);
    rdp(8'h6c, 4'h0, 12'h000);
    rdp(8'h6e, 4'h0, 12'h000);
    regWr <= 1'b1;
    regAddr <= 8'h1b;
    tick(1);
    regWr <= 1'b0;
    rdp(8'h59, 4'h0, 12'h000);
    cmp({7'h0, rsvdWriteSeen}, 8'h01);
    legacyEn <= 4'hc;
    autoMode <= 1'b1;
    for (int s = 1; s < 7; s++) begin
      stat <= s[3:0];
      cnt <= 12'($urandom);
      lat <= 4'($urandom_range(1, 6));
      tick(60);
      rdp(8'h6c, s[3:0], cnt);
      rdp(8'h6e, s[3:0], cnt);
    end
    oc = cnt;
    autoMode <= 1'b0;
    // a measurement still in flight may land; let it pass first
    tick(4);
    cnt <= ~cnt;
    stat <= 4'h2;
    tick(36);
    rdp(8'h6c, 4'h6, oc);
    legacyEn <= 4'h4;
    autoMode <= 1'b1;
    tick(60);
    rdp(8'h6e, 4'h6, oc);
    rdp(8'h6c, 4'h2, ~oc);
    autoMode <= 1'b0;
    legacyEn <= 4'hc;
    tick(4);
    rdp(8'h6e, 4'h0, oc);
    autoMode <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      cls <= c[2:0];
      {powerOffCmd, mpsLost} <= c[0] ? 8'h01 : 8'h10;
      tick(1);
      {powerOffCmd, mpsLost} <= 8'h00;
      tick(40);
      cmp({7'h0, portPowerEn[0]}, {7'h0, c < 5});
      if (c < 5) cmp({5'h0, portClass[2:0]}, {5'h0, c[2:0]});
    end
    cls <= 3'h0;
    for (int k = 0; k < 4; k++) begin
      cooldown_period_sel <= k[1:0];
      tick(40);
      {startFault, overload_cut_limit, hard_current_limit}
        <= 12'h1 << (4 * (k % 3));
      tick(1);
      {startFault, overload_cut_limit, hard_current_limit} <= 12'h000;
      n = 0;
      ex = ((k < 2) ? 1000 : 1000 << (k - 1)) * CPM;
      while (detectReq[0] !== 1'b1 && n < 20000) begin
        @(negedge clk);
        n++;
      end
      cmp({7'h0, n >= ex - 2 && n <= ex + 4}, 8'h01);
    end
    tick(40);
    supplyBelowUv <= 1'b1;
    tick(6);
    @(negedge clk);
    cmp({3'h0, uvLockout, portPowerEn}, 8'h10);
    tick(1);
    supplyBelowUv <= 1'b0;
    tick(60);
    @(negedge clk);
    cmp({6'h0, uvLockout, portPowerEn[0]}, 8'h01);
    tick(4);
    give_verdict();
  end
endmodule // pps_port_seq_tb
